// File: include/icr_pkg.sv
// shared constants and types for the id and reference control register slice
package icr_pkg;

	// ----------------------------------------------------------------
	// register offsets (serial address space)
	// ----------------------------------------------------------------
	localparam logic [14:0] ADDR_CONFIG_A    = 15'h0000;
	localparam logic [14:0] ADDR_PART_ID     = 15'h0004;
	localparam logic [14:0] ADDR_MAKER_ID    = 15'h000C;
	localparam logic [14:0] ADDR_SER_USER    = 15'h0010;
	localparam logic [14:0] ADDR_REF_CTRL_P  = 15'h0029;
	localparam logic [14:0] ADDR_REF_CTRL_S  = 15'h002A;
	localparam logic [14:0] ADDR_REF_POS_LO  = 15'h002C;

	// ----------------------------------------------------------------
	// fixed identification values (arbitrary neutral values)
	// ----------------------------------------------------------------
	localparam logic [15:0] PART_ID_DEFAULT  = 16'h5A3C;
	localparam logic [15:0] MAKER_ID_DEFAULT = 16'h0E71;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_CONFIG_A      = 8'h20;
	localparam logic [7:0] RST_SER_USER      = 8'h00;
	localparam logic [7:0] RST_REF_CTRL_P    = 8'h00;
	localparam logic [7:0] RST_REF_CTRL_S    = 8'h00;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int BIT_ASCEND                = 5;
	localparam int BIT_SDO_ACTIVE            = 4;
	localparam int BIT_ADDR_FREEZE           = 0;
	localparam int BIT_PROC_ON               = 6;
	localparam int BIT_RECV_ON               = 5;
	localparam int BIT_FINE_SCALE            = 4;
	localparam int BIT_DELAY_HI              = 3;
	localparam int BIT_DELAY_LO              = 0;
	localparam int BIT_MARKER_ON             = 3;
	localparam int BIT_CLK_DC                = 2;
	localparam int BIT_REF_DC                = 1;
	localparam int BIT_POL_FLIP              = 0;

	// ----------------------------------------------------------------
	// serial frame layout
	// ----------------------------------------------------------------
	localparam int HDR_BITS                  = 16;
	localparam int DATA_BITS                 = 8;

	// ----------------------------------------------------------------
	// control outputs to the analog and sample path
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       ref_event_processor_on;
		logic       ref_receiver_on;
		logic       window_fine_scale;
		logic [3:0] ref_delay_choice;
		logic       ref_as_marker_on;
		logic       clock_input_dc_mode;
		logic       ref_input_dc_mode;
		logic       ref_polarity_flip;
	} icr_ctrl_t;

	typedef enum logic [2:0] {
		ST_HDR  = 3'b001,
		ST_WR   = 3'b010,
		ST_RD   = 3'b100
	} icr_state_t;

endpackage

// File: src/icr_regs.sv
// serial register slice: identification, streaming address control, reference clock control
`timescale 1ns/1ps
module icr_regs
	import icr_pkg::*;
(
	// clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        nrst_i,
	// serial host pins
	input  wire logic        sclk_i,
	input  wire logic        scs_n_i,
	input  wire logic        sdi_i,
	output logic             sdo_o,
	output logic             sdo_oe_n_o,
	// reference pulse path
	input  wire logic        ref_pulse_i,
	input  wire logic        sample_marker_on_i,
	input  wire logic [23:0] ref_edge_position_status_i,
	output logic             ref_event_o,
	output logic             sample_lsb_marker_o,
	// control fields
	output icr_ctrl_t        ctrl_o
);

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [1:0] sclk_s, cs_s, sdi_s, ref_s;
	logic       sclk_d;

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sclk_s <= 2'h0;
			cs_s   <= 2'h3;
			sdi_s  <= 2'h0;
			ref_s  <= 2'h0;
			sclk_d <= 1'b0;
		end else begin
			sclk_s <= {sclk_s[0], sclk_i};
			cs_s   <= {cs_s[0], scs_n_i};
			sdi_s  <= {sdi_s[0], sdi_i};
			ref_s  <= {ref_s[0], ref_pulse_i};
			sclk_d <= sclk_s[1];
		end
	end

	logic sclk_rise, sclk_fall, sel;
	assign sclk_rise = sclk_s[1] & ~sclk_d;
	assign sclk_fall = ~sclk_s[1] & sclk_d;
	assign sel       = ~cs_s[1];

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [7:0] config_a, serial_user_config;
	logic [7:0] reference_control_primary, reference_control_secondary;
	logic [7:0] next_config_a, next_serial_user_config;
	logic [7:0] next_reference_control_primary, next_reference_control_secondary;

	// ----------------------------------------------------------------
	// serial frame engine
	// ----------------------------------------------------------------
	icr_state_t  state, next_state;
	logic [4:0]  bcnt, next_bcnt;
	logic [15:0] shreg, next_shreg;
	logic [14:0] addr, next_addr;
	logic [7:0]  rdsh, next_rdsh;
	logic        wr_stb;
	logic [7:0]  wr_byte;

	function automatic logic [7:0] rd_reg(input logic [14:0] a);
		case (a)
			ADDR_CONFIG_A:         rd_reg = config_a | (8'h01 << BIT_SDO_ACTIVE);
			ADDR_PART_ID:          rd_reg = PART_ID_DEFAULT[7:0];
			ADDR_PART_ID + 15'h1:  rd_reg = PART_ID_DEFAULT[15:8];
			ADDR_MAKER_ID:         rd_reg = MAKER_ID_DEFAULT[7:0];
			ADDR_MAKER_ID + 15'h1: rd_reg = MAKER_ID_DEFAULT[15:8];
			ADDR_SER_USER:         rd_reg = serial_user_config;
			ADDR_REF_CTRL_P:       rd_reg = reference_control_primary;
			ADDR_REF_CTRL_S:       rd_reg = reference_control_secondary;
			ADDR_REF_POS_LO:       rd_reg = ref_edge_position_status_i[7:0];
			ADDR_REF_POS_LO + 15'h1: rd_reg = ref_edge_position_status_i[15:8];
			ADDR_REF_POS_LO + 15'h2: rd_reg = ref_edge_position_status_i[23:16];
			default:               rd_reg = 8'h00;
		endcase
	endfunction

	function automatic logic [14:0] step(input logic [14:0] a);
		if (serial_user_config[BIT_ADDR_FREEZE])
			step = a;
		else if (config_a[BIT_ASCEND])
			step = a + 15'h1;
		else
			step = a - 15'h1;
	endfunction

	always_comb begin
		next_state = state;
		next_bcnt  = bcnt;
		next_shreg = shreg;
		next_addr  = addr;
		next_rdsh  = rdsh;
		wr_stb     = 1'b0;
		wr_byte    = 8'h00;
		if (!sel) begin
			next_state = ST_HDR;
			next_bcnt  = 5'h00;
		end else begin
			case (state)
				ST_HDR: begin
					if (sclk_rise) begin
						next_shreg = {shreg[14:0], sdi_s[1]};
						next_bcnt  = bcnt + 5'h01;
						if (bcnt == 5'(HDR_BITS - 1)) begin
							next_bcnt = 5'h00;
							next_addr = next_shreg[14:0];
							if (next_shreg[15]) begin
								next_state = ST_RD;
								next_rdsh  = rd_reg(next_shreg[14:0]);
							end else begin
								next_state = ST_WR;
							end
						end
					end
				end
				ST_WR: begin
					if (sclk_rise) begin
						next_shreg = {shreg[14:0], sdi_s[1]};
						next_bcnt  = bcnt + 5'h01;
						if (bcnt == 5'(DATA_BITS - 1)) begin
							next_bcnt = 5'h00;
							wr_stb    = 1'b1;
							wr_byte   = next_shreg[7:0];
							next_addr = step(addr);
						end
					end
				end
				ST_RD: begin
					// count bits taken; the fall closing the header keeps the first bit
					if (sclk_rise) begin
						next_bcnt = bcnt + 5'h01;
					end
					if (sclk_fall && bcnt != 5'h00) begin
						if (bcnt == 5'(DATA_BITS)) begin
							next_bcnt = 5'h00;
							next_addr = step(addr);
							next_rdsh = rd_reg(step(addr));
						end else begin
							next_rdsh = {rdsh[6:0], 1'b0};
						end
					end
				end
				default: begin
					next_state = ST_HDR;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state <= ST_HDR;
			bcnt  <= 5'h00;
			shreg <= 16'h0000;
			addr  <= 15'h0000;
			rdsh  <= 8'h00;
		end else begin
			state <= next_state;
			bcnt  <= next_bcnt;
			shreg <= next_shreg;
			addr  <= next_addr;
			rdsh  <= next_rdsh;
		end
	end

	// ----------------------------------------------------------------
	// register write decode
	// ----------------------------------------------------------------
	always_comb begin
		next_config_a                    = config_a;
		next_serial_user_config          = serial_user_config;
		next_reference_control_primary   = reference_control_primary;
		next_reference_control_secondary = reference_control_secondary;
		if (wr_stb) begin
			case (addr)
				ADDR_CONFIG_A:   next_config_a = wr_byte & 8'h6F;
				ADDR_SER_USER:   next_serial_user_config = wr_byte;
				ADDR_REF_CTRL_P: next_reference_control_primary = wr_byte;
				ADDR_REF_CTRL_S: next_reference_control_secondary = wr_byte;
				default: ;
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			config_a                    <= RST_CONFIG_A;
			serial_user_config          <= RST_SER_USER;
			reference_control_primary   <= RST_REF_CTRL_P;
			reference_control_secondary <= RST_REF_CTRL_S;
		end else begin
			config_a                    <= next_config_a;
			serial_user_config          <= next_serial_user_config;
			reference_control_primary   <= next_reference_control_primary;
			reference_control_secondary <= next_reference_control_secondary;
		end
	end

	// ----------------------------------------------------------------
	// control fields and reference path
	// ----------------------------------------------------------------
	logic ref_lvl, ref_lvl_d, next_ref_event, next_marker;
	logic ref_event_q, marker_q;

	always_comb begin
		ctrl_o.ref_event_processor_on = reference_control_primary[BIT_PROC_ON];
		ctrl_o.ref_receiver_on        = reference_control_primary[BIT_RECV_ON];
		ctrl_o.window_fine_scale      = reference_control_primary[BIT_FINE_SCALE];
		ctrl_o.ref_delay_choice       = reference_control_primary[BIT_DELAY_HI:BIT_DELAY_LO];
		ctrl_o.ref_as_marker_on       = reference_control_secondary[BIT_MARKER_ON];
		ctrl_o.clock_input_dc_mode    = reference_control_secondary[BIT_CLK_DC];
		ctrl_o.ref_input_dc_mode      = reference_control_secondary[BIT_REF_DC];
		ctrl_o.ref_polarity_flip      = reference_control_secondary[BIT_POL_FLIP];
		ref_lvl        = (ref_s[1] ^ reference_control_secondary[BIT_POL_FLIP])
		                 & reference_control_primary[BIT_RECV_ON];
		next_ref_event = ref_lvl & ~ref_lvl_d & reference_control_primary[BIT_PROC_ON];
		next_marker    = ref_lvl & reference_control_secondary[BIT_MARKER_ON]
		                 & sample_marker_on_i;
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ref_lvl_d   <= 1'b0;
			ref_event_q <= 1'b0;
			marker_q    <= 1'b0;
		end else begin
			ref_lvl_d   <= ref_lvl;
			ref_event_q <= next_ref_event;
			marker_q    <= next_marker;
		end
	end

	assign ref_event_o         = ref_event_q;
	assign sample_lsb_marker_o = marker_q;
	assign sdo_o               = rdsh[7];
	assign sdo_oe_n_o          = ~(sel && (state == ST_RD));

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	AST_PROC_GATE: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		ref_event_o |-> $past(reference_control_primary[BIT_PROC_ON]))
		else $error("reference event with processor off");
	AST_RECV_GATE: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		!reference_control_primary[BIT_RECV_ON] |=> !ref_event_o && !sample_lsb_marker_o)
		else $error("reference output with receiver off");
	AST_MARKER: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		sample_lsb_marker_o |-> $past(reference_control_secondary[BIT_MARKER_ON] & sample_marker_on_i))
		else $error("marker without both enables");
	AST_FREEZE: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(wr_stb && serial_user_config[BIT_ADDR_FREEZE]) |=> $stable(addr))
		else $error("address moved while frozen");
	AST_INC: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(wr_stb && !serial_user_config[BIT_ADDR_FREEZE] && config_a[BIT_ASCEND])
		|=> addr == $past(addr) + 15'h1)
		else $error("address did not increment");
	AST_DEC: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(wr_stb && !serial_user_config[BIT_ADDR_FREEZE] && !config_a[BIT_ASCEND])
		|=> addr == $past(addr) - 15'h1)
		else $error("address did not decrement");
	AST_ID_RO: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(wr_stb && (addr == ADDR_PART_ID || addr == ADDR_PART_ID + 15'h1 || addr == ADDR_MAKER_ID
		|| addr == ADDR_MAKER_ID + 15'h1)) |=> $stable({config_a, serial_user_config,
		reference_control_primary, reference_control_secondary}))
		else $error("identification write changed a register");
	AST_PART_READ: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(state == ST_HDR && next_state == ST_RD && next_addr == ADDR_PART_ID) |=> rdsh == PART_ID_DEFAULT[7:0])
		else $error("part identifier read wrong");
	AST_MAKER_READ: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(state == ST_HDR && next_state == ST_RD && next_addr == ADDR_MAKER_ID + 15'h1)
		|=> rdsh == MAKER_ID_DEFAULT[15:8])
		else $error("maker identifier read wrong");
	AST_RD_FIRST: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(state == ST_RD && sclk_fall && bcnt == 5'h00) |=> $stable(rdsh))
		else $error("read data shifted before the host took it");
	AST_DELAY: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(wr_stb && addr == ADDR_REF_CTRL_P) |=> ctrl_o.ref_delay_choice == $past(wr_byte[3:0]))
		else $error("delay choice not applied");
	AST_FLIP: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(wr_stb && addr == ADDR_REF_CTRL_S) |=> ctrl_o.ref_polarity_flip == $past(wr_byte[0])
		&& ctrl_o.clock_input_dc_mode == $past(wr_byte[2]))
		else $error("secondary control not applied");

endmodule

// File: bench/icr_spi_host.sv
// serial host model that frames reads and writes for the register slice
`timescale 1ns/1ps
module icr_spi_host (
	// clock
	input  wire logic ref_clk_i,
	// serial pins
	output logic      sclk_o,
	output logic      scs_n_o,
	output logic      sdi_o,
	input  wire logic sdo_i
);
	// half serial period in clocks, well above the synchroniser minimum
	localparam int HALF = 8;

	initial begin
		sclk_o  = 1'b0;
		scs_n_o = 1'b1;
		sdi_o   = 1'b1;
	end

	task automatic half_wait();
		repeat (HALF) @(posedge ref_clk_i);
		#1;
	endtask

	// one frame: header then n bytes msb first, data right aligned
	task automatic xfer(input logic rd, input logic [14:0] addr, input int n, input logic [31:0] wd,
		output logic [31:0] rdat);
		logic [15:0] hdr;
		logic [31:0] tx;
		hdr     = {rd, addr};
		tx      = wd << (32 - 8 * n);
		rdat    = 32'h0;
		scs_n_o = 1'b0;
		for (int i = 0; i < 16 + 8 * n; i++) begin
			if (i < 16) begin
				sdi_o = hdr[15 - i];
			end else begin
				sdi_o = tx[31];
				tx    = tx << 1;
			end
			half_wait();
			if (i >= 16) begin
				rdat = {rdat[30:0], sdo_i};
			end
			sclk_o = 1'b1;
			half_wait();
			sclk_o = 1'b0;
		end
		half_wait();
		scs_n_o = 1'b1;
		// released data line must not keep its last value
		sdi_o   = ~sdi_o;
		half_wait();
	endtask
endmodule

// File: bench/icr_regs_tb.sv
// self-checking bench for the id and reference control register slice
`timescale 1ns/1ps
module icr_regs_tb;
	import icr_pkg::*;

	logic        ref_clk_i = 1'b0;
	logic        nrst_i    = 1'b0;
	logic        sclk, scs_n, sdi, sdo, sdo_oe_n;
	logic        ref_pulse = 1'b0;
	logic        marker_on = 1'b0;
	logic [23:0] status    = 24'hA5C3E1;
	logic        ref_event, lsb_marker;
	icr_ctrl_t   ctrl;
	int          mismatches = 0;
	int          n_checks   = 0;
	int          cnt;
	logic [31:0] rdat;

	// rows: address, write value, expected readback
	localparam logic [30:0] ROWS [8] = '{
		{15'h0029, 8'h20, 8'h20}, {15'h0029, 8'h7A, 8'h7A}, {15'h002A, 8'hFF, 8'hFF},
		{15'h002A, 8'h0F, 8'h0F}, {15'h0004, 8'hFF, PART_ID_DEFAULT[7:0]},
		{15'h0005, 8'h00, PART_ID_DEFAULT[15:8]}, {15'h000C, 8'hFF, MAKER_ID_DEFAULT[7:0]},
		{15'h000D, 8'h00, MAKER_ID_DEFAULT[15:8]}};

	always #2.5 ref_clk_i = ~ref_clk_i;

	icr_spi_host i_icr_spi_host (.ref_clk_i(ref_clk_i), .sclk_o(sclk), .scs_n_o(scs_n), .sdi_o(sdi), .sdo_i(sdo));

	icr_regs i_icr_regs (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .sclk_i(sclk), .scs_n_i(scs_n), .sdi_i(sdi),
		.sdo_o(sdo), .sdo_oe_n_o(sdo_oe_n), .ref_pulse_i(ref_pulse), .sample_marker_on_i(marker_on),
		.ref_edge_position_status_i(status), .ref_event_o(ref_event), .sample_lsb_marker_o(lsb_marker),
		.ctrl_o(ctrl));

	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			$display("mismatch %s expected %h seen %h", what, exp, got);
			mismatches++;
		end
	endtask

	task automatic chk_cnt(input string what, input int exp, input int got);
		n_checks++;
		if (got != exp) begin
			$display("mismatch %s expected %0d seen %0d", what, exp, got);
			mismatches++;
		end
	endtask

	task automatic wr(input logic [14:0] addr, input int n, input logic [31:0] wd);
		logic [31:0] junk;
		i_icr_spi_host.xfer(1'b0, addr, n, wd, junk);
	endtask

	task automatic rd(input logic [14:0] addr, input int n, output logic [31:0] q);
		i_icr_spi_host.xfer(1'b1, addr, n, 32'h0, q);
	endtask

	// count event pulses over n clocks
	task automatic watch(input int n, output int c);
		c = 0;
		repeat (n) begin
			@(posedge ref_clk_i);
			#1;
			if (ref_event === 1'b1) c++;
		end
	endtask

	// ----------------------------------------------------------------
	// watchdog
	// ----------------------------------------------------------------
	initial begin
		repeat (60000) @(posedge ref_clk_i);
		mismatches++;
		stop_test();
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (4) @(posedge ref_clk_i);
		#1;
		nrst_i = 1'b1;
		repeat (4) @(posedge ref_clk_i);
		#1;
		chk_val("ctrl after reset", 32'h0, 32'(ctrl));
		chk_val("sdo enable after reset", 32'h1, 32'(sdo_oe_n));
		rd(ADDR_SER_USER, 1, rdat);
		chk_val("user reset", 32'h00, rdat);
		rd(ADDR_REF_CTRL_P, 2, rdat);
		chk_val("ref ctrl reset", 32'h0000, rdat);
		$display("test reset done");
		// receiver enabled in an earlier write than the processor
		for (int i = 0; i < 8; i++) begin
			wr(ROWS[i][30:16], 1, 32'(ROWS[i][15:8]));
			rd(ROWS[i][30:16], 1, rdat);
			chk_val("readback", 32'(ROWS[i][7:0]), rdat);
		end
		chk_val("ctrl fields", 32'({1'b1, 1'b1, 1'b1, 4'hA, 4'hF}), 32'(ctrl));
		$display("test table done");
		wr(ADDR_REF_CTRL_P, 2, 32'h250A);
		rd(ADDR_REF_CTRL_P, 2, rdat);
		chk_val("ascend stream", 32'h250A, rdat);
		rd(ADDR_REF_POS_LO, 3, rdat);
		chk_val("status ascend", 32'hE1C3A5, rdat);
		wr(ADDR_CONFIG_A, 1, 32'h00);
		rd(15'h002E, 3, rdat);
		chk_val("status descend", 32'hA5C3E1, rdat);
		$display("test stream done");
		wr(ADDR_SER_USER, 1, 32'h01);
		rd(ADDR_MAKER_ID, 2, rdat);
		chk_val("frozen read", 32'(MAKER_ID_DEFAULT[7:0]) * 32'h101, rdat);
		wr(ADDR_REF_CTRL_P, 2, 32'h2060);
		rd(ADDR_REF_CTRL_P, 2, rdat);
		chk_val("frozen write", 32'h6060, rdat);
		rd(ADDR_REF_CTRL_S, 1, rdat);
		chk_val("neighbour untouched", 32'h0A, rdat);
		$display("test freeze done");
		wr(ADDR_REF_CTRL_S, 1, 32'h08);
		ref_pulse = 1'b1;
		watch(20, cnt);
		chk_cnt("event on rise", 1, cnt);
		marker_on = 1'b1;
		repeat (8) @(posedge ref_clk_i);
		#1;
		chk_val("marker on", 32'h1, 32'(lsb_marker));
		marker_on = 1'b0;
		repeat (8) @(posedge ref_clk_i);
		#1;
		chk_val("marker gated", 32'h0, 32'(lsb_marker));
		ref_pulse = 1'b0;
		watch(20, cnt);
		chk_cnt("no event on fall", 0, cnt);
		wr(ADDR_REF_CTRL_S, 1, 32'h01);
		ref_pulse = 1'b1;
		watch(20, cnt);
		chk_cnt("flipped rise", 0, cnt);
		ref_pulse = 1'b0;
		watch(20, cnt);
		chk_cnt("flipped fall", 1, cnt);
		wr(ADDR_REF_CTRL_P, 1, 32'h20);
		ref_pulse = 1'b1;
		watch(20, cnt);
		ref_pulse = 1'b0;
		watch(20, cnt);
		chk_cnt("processor off", 0, cnt);
		$display("test events done");
		stop_test();
	end
endmodule
